// ==== core/rx_filter_top.sv ====
// Summary of operation
// - Request the bus when transmit FIFO words fall below the threshold.
// - Two-bit level code picks 4, 8, 12 or 14 words.
// - In block mode one burst reads the threshold amount.
// - If less room than threshold, burst reads only enough to fill.
// - Writing ones to bits 15 to 11 enables the matching filter.
// - All filters off means only address table matches are accepted.
// - Bits 10 and 9 select loopback operation.
// - Status bits 8-6 and 4-0 set for the accepted frame; bit 5 follows carrier; all read-only.
// - Whole control register copied to descriptor status of accepted frame.
// - Next frame clears bits 8-6 and 3-0, not carrier or collision.
// - Software reset leaves the control register unchanged.
// - Error bit clear rejects checksum or collision frames; set accepts.
// - Short-frame bit set accepts frames below 64 bytes.
// - Hardware reset clears the short-frame bit.
// - Broadcast bit set accepts broadcasts plus table matches.
// - Hardware reset clears the broadcast bit.
// - Promiscuous bit accepts all individual destination frames.
// - All-multicast bit accepts every multicast frame.
// - All-multicast bit also accepts broadcasts regardless of broadcast bit.
// - Empty/fill mode keeps transferring until transmit FIFO is full.
// - Multicast seen bit set for accepted multicast frames.
// - Good bit set only without checksum, framing, short or collision.
// - Framing bit only with checksum fault; else checksum bit alone.
`timescale 1ns/1ps
module rx_filter_top (
  input  wire logic                       mclk_i,              // System clock
  input  wire logic                       rst_n_i,             // Hardware reset, low
  input  wire logic                       sw_reset_i,          // Software reset
  input  wire logic [5:0]                 reg_sel_i,           // Register select lines
  input  wire logic                       reg_cs_i,            // Register port select
  input  wire logic                       reg_wr_i,            // Write strobe
  input  wire logic                       reg_rd_i,            // Read strobe
  input  wire logic [15:0]                reg_wdata_i,         // Write data
  output logic [15:0]                     reg_rdata_o,         // Read data
  input  wire logic                       frame_start_i,       // Next frame begins
  input  wire logic                       frame_end_i,         // Frame complete
  input  wire rxf_pkg::rx_frame_info_type frame_info_i,        // Frame facts at end
  input  wire logic                       carrier_i,           // Carrier activity
  output logic                            frame_accept_o,      // Frame accepted pulse
  output logic                            frame_reject_o,      // Frame rejected pulse
  output logic                            desc_status_valid_o, // Descriptor word valid
  output logic [15:0]                     desc_status_o,       // Descriptor status word
  output logic [1:0]                      loop_select_o,       // Loopback select
  input  wire rxf_pkg::tx_dma_cfg_type    tx_cfg_i,            // Transmit DMA setup
  input  wire logic [4:0]                 tx_fifo_words_i,     // Transmit FIFO words
  input  wire logic                       dma_grant_i,         // Bus granted
  input  wire logic                       dma_read_done_i,     // Word read done
  output logic                            dma_bus_req_o,       // Bus request
  output logic [4:0]                      dma_burst_left_o     // Reads left
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    rxf_pkg::rx_state_type rx_state;
    logic [15:0]           ctrl;
    logic                  accept;
    logic                  reject;
    logic                  desc_valid;
    logic [15:0]           desc;
    logic [15:0]           rdata;
  } top_regs_type;

  top_regs_type s_q;
  top_regs_type s_d;

  logic reg_hit;
  logic wr_hit;
  logic rd_hit;
  logic err_ok;
  logic short_ok;
  logic addr_ok;
  logic take;
  logic loop_on;
  logic good;
  logic [15:0] status_set;

  // ****************************************
  // Register port decode
  // ****************************************
  always_comb begin
    reg_hit = reg_cs_i && (reg_sel_i == rxf_pkg::CTRL_SEL);
    wr_hit  = reg_hit && reg_wr_i;
    rd_hit  = reg_hit && reg_rd_i;
  end

  // ****************************************
  // Acceptance decision
  // ****************************************
  always_comb begin
    err_ok = s_q.ctrl[rxf_pkg::BIT_ERR] ||
             !(frame_info_i.checksum_fault || frame_info_i.collision);
    short_ok = s_q.ctrl[rxf_pkg::BIT_SHORT] ||
               !frame_info_i.short_frame;
    addr_ok = frame_info_i.dest_match;
    if (s_q.ctrl[rxf_pkg::BIT_BCAST] && frame_info_i.dest_broadcast) begin
      addr_ok = 1'b1;
    end
    if (s_q.ctrl[rxf_pkg::BIT_PHYS] && !frame_info_i.dest_multicast) begin
      addr_ok = 1'b1;
    end
    if (s_q.ctrl[rxf_pkg::BIT_MCAST] &&
        (frame_info_i.dest_multicast || frame_info_i.dest_broadcast)) begin
      addr_ok = 1'b1;
    end
    if (s_q.ctrl[rxf_pkg::BIT_ERR] &&
        (frame_info_i.checksum_fault || frame_info_i.collision) &&
        frame_info_i.dest_match) begin
      addr_ok = 1'b1;
    end
    take = addr_ok && err_ok && short_ok;
  end

  // ****************************************
  // Status bits for the finished frame
  // ****************************************
  always_comb begin
    loop_on = s_q.ctrl[rxf_pkg::BIT_LOOP_HI] ||
              s_q.ctrl[rxf_pkg::BIT_LOOP_LO];
    good = !frame_info_i.checksum_fault &&
           !frame_info_i.framing_fault &&
           !frame_info_i.short_frame &&
           !frame_info_i.collision;
    status_set = 16'h0000;
    status_set[rxf_pkg::BIT_MCAST_RX] = frame_info_i.dest_multicast;
    status_set[rxf_pkg::BIT_BCAST_RX] = frame_info_i.dest_broadcast;
    status_set[rxf_pkg::BIT_FINAL]   = frame_info_i.final_frame_in_area;
    status_set[rxf_pkg::BIT_COLL]    = frame_info_i.collision;
    status_set[rxf_pkg::BIT_CRC]     = frame_info_i.checksum_fault &&
                                       !frame_info_i.framing_fault;
    status_set[rxf_pkg::BIT_FRAMING] = frame_info_i.checksum_fault &&
                                       frame_info_i.framing_fault;
    status_set[rxf_pkg::BIT_LOOPED]  = frame_info_i.looped && loop_on && good;
    status_set[rxf_pkg::BIT_GOOD]    = good;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d            = s_q;
    s_d.accept     = 1'b0;
    s_d.reject     = 1'b0;
    s_d.desc_valid = 1'b0;

    // Frame tracking
    case (s_q.rx_state)
      rxf_pkg::RX_IDLE: begin
        if (frame_start_i && !frame_end_i) begin
          s_d.rx_state = rxf_pkg::RX_BUSY;
        end
      end
      rxf_pkg::RX_BUSY: begin
        if (frame_end_i && !frame_start_i) begin
          s_d.rx_state = rxf_pkg::RX_IDLE;
        end
      end
      default: begin
        s_d.rx_state = rxf_pkg::RX_IDLE;
      end
    endcase

    // Software writes only the filter and loopback bits
    if (wr_hit) begin
      s_d.ctrl = (s_q.ctrl & ~rxf_pkg::CTRL_WMASK) |
                 (reg_wdata_i & rxf_pkg::CTRL_WMASK);
    end

    // Next frame clears the per-frame status
    if (frame_start_i) begin
      s_d.ctrl = s_d.ctrl & ~rxf_pkg::CTRL_NEXT_CLR;
    end

    // Live carrier activity
    s_d.ctrl[rxf_pkg::BIT_CARRIER] = carrier_i;

    // Accepted frame sets status; set wins over the start clear
    if (frame_end_i) begin
      if (take) begin
        s_d.ctrl[8:0]  = (s_d.ctrl[8:0] & ~rxf_pkg::CTRL_NEXT_CLR[8:0]) |
                         status_set[8:0];
        s_d.ctrl[rxf_pkg::BIT_COLL] = frame_info_i.collision;
        s_d.accept     = 1'b1;
        s_d.desc_valid = 1'b1;
        s_d.desc       = s_d.ctrl;
      end else begin
        s_d.reject = 1'b1;
      end
    end

    // Registered read answer
    if (rd_hit) begin
      s_d.rdata = s_q.ctrl;
    end else begin
      s_d.rdata = rxf_pkg::RDATA_IDLE;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q.rx_state   <= rxf_pkg::RX_IDLE;
      s_q.ctrl       <= rxf_pkg::CTRL_RESET;
      s_q.accept     <= 1'b0;
      s_q.reject     <= 1'b0;
      s_q.desc_valid <= 1'b0;
      s_q.desc       <= 16'h0000;
      s_q.rdata      <= 16'h0000;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Transmit DMA pacing
  // ****************************************
  tx_dma_pacer u_pacer (
    .mclk_i       (mclk_i),
    .rst_n_i      (rst_n_i),
    .sw_reset_i   (sw_reset_i),
    .cfg_i        (tx_cfg_i),
    .fifo_words_i (tx_fifo_words_i),
    .grant_i      (dma_grant_i),
    .read_done_i  (dma_read_done_i),
    .bus_req_o    (dma_bus_req_o),
    .burst_left_o (dma_burst_left_o)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata_o         = s_q.rdata;
  assign frame_accept_o      = s_q.accept;
  assign frame_reject_o      = s_q.reject;
  assign desc_status_valid_o = s_q.desc_valid;
  assign desc_status_o       = s_q.desc;
  assign loop_select_o       = s_q.ctrl[10:9];

endmodule

// ==== core/rxf_pkg.sv ====
package rxf_pkg;

  // ****************************************
  // Register select and field positions
  // ****************************************
  localparam logic [5:0]  CTRL_SEL      = 6'h02;
  localparam int unsigned BIT_ERR       = 15;
  localparam int unsigned BIT_SHORT     = 14;
  localparam int unsigned BIT_BCAST     = 13;
  localparam int unsigned BIT_PHYS      = 12;
  localparam int unsigned BIT_MCAST     = 11;
  localparam int unsigned BIT_LOOP_HI   = 10;
  localparam int unsigned BIT_LOOP_LO   = 9;
  localparam int unsigned BIT_MCAST_RX  = 8;
  localparam int unsigned BIT_BCAST_RX  = 7;
  localparam int unsigned BIT_FINAL     = 6;
  localparam int unsigned BIT_CARRIER   = 5;
  localparam int unsigned BIT_COLL      = 4;
  localparam int unsigned BIT_CRC       = 3;
  localparam int unsigned BIT_FRAMING   = 2;
  localparam int unsigned BIT_LOOPED    = 1;
  localparam int unsigned BIT_GOOD      = 0;

  // ****************************************
  // Reset value and masks
  // ****************************************
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] CTRL_WMASK    = 16'hFE00;
  localparam logic [15:0] CTRL_NEXT_CLR = 16'h01CF;
  localparam logic [15:0] RDATA_IDLE    = 16'h0000;

  // ****************************************
  // Transmit FIFO levels in words
  // ****************************************
  localparam logic [4:0]  TX_LVL_0      = 5'h04;
  localparam logic [4:0]  TX_LVL_1      = 5'h08;
  localparam logic [4:0]  TX_LVL_2      = 5'h0C;
  localparam logic [4:0]  TX_LVL_3      = 5'h0E;
  localparam logic [4:0]  TX_FIFO_WORDS = 5'h10;
  localparam logic [4:0]  COUNT_ZERO    = 5'h00;
  localparam logic [4:0]  COUNT_ONE     = 5'h01;

  // ****************************************
  // Carriers and states
  // ****************************************
  typedef struct packed {
    logic dest_match;
    logic dest_broadcast;
    logic dest_multicast;
    logic checksum_fault;
    logic framing_fault;
    logic short_frame;
    logic collision;
    logic looped;
    logic final_frame_in_area;
  } rx_frame_info_type;

  typedef struct packed {
    logic [1:0] tx_fifo_level_code;
    logic       dma_burst_mode_select;
  } tx_dma_cfg_type;

  typedef enum logic [2:0] {
    PACE_IDLE  = 3'b001,
    PACE_REQ   = 3'b010,
    PACE_BURST = 3'b100
  } pace_state_type;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_BUSY = 2'b10
  } rx_state_type;

endpackage

// ==== core/tx_dma_pacer.sv ====
`timescale 1ns/1ps
module tx_dma_pacer (
  input  wire logic                    mclk_i,       // System clock
  input  wire logic                    rst_n_i,      // Async reset, low
  input  wire logic                    sw_reset_i,   // Software reset
  input  wire rxf_pkg::tx_dma_cfg_type cfg_i,        // Level code, burst mode
  input  wire logic [4:0]              fifo_words_i, // Words held in FIFO
  input  wire logic                    grant_i,      // Bus granted
  input  wire logic                    read_done_i,  // One word read done
  output logic                         bus_req_o,    // Bus request
  output logic [4:0]                   burst_left_o  // Reads left in burst
);

  typedef struct packed {
    rxf_pkg::pace_state_type state;
    logic [4:0]              left;
    logic                    req;
  } pace_regs_type;

  pace_regs_type r_q;
  pace_regs_type r_d;
  logic [4:0]    level;
  logic [4:0]    room;

  // ****************************************
  // Level decode and burst size
  // ****************************************
  always_comb begin
    case (cfg_i.tx_fifo_level_code)
      2'b00:   level = rxf_pkg::TX_LVL_0;
      2'b01:   level = rxf_pkg::TX_LVL_1;
      2'b10:   level = rxf_pkg::TX_LVL_2;
      default: level = rxf_pkg::TX_LVL_3;
    endcase
    room = rxf_pkg::TX_FIFO_WORDS - fifo_words_i;
  end

  // ****************************************
  // Request and burst sequencing
  // ****************************************
  always_comb begin
    r_d = r_q;
    case (r_q.state)
      rxf_pkg::PACE_IDLE: begin
        if (fifo_words_i < level) begin
          r_d.req   = 1'b1;
          r_d.state = rxf_pkg::PACE_REQ;
        end
      end
      rxf_pkg::PACE_REQ: begin
        if (grant_i) begin
          if (cfg_i.dma_burst_mode_select && (room > level)) begin
            r_d.left = level;
          end else begin
            r_d.left = room;
          end
          r_d.state = rxf_pkg::PACE_BURST;
        end
      end
      rxf_pkg::PACE_BURST: begin
        if (read_done_i || (r_q.left == rxf_pkg::COUNT_ZERO)) begin
          if (r_q.left <= rxf_pkg::COUNT_ONE) begin
            r_d.left  = rxf_pkg::COUNT_ZERO;
            r_d.req   = 1'b0;
            r_d.state = rxf_pkg::PACE_IDLE;
          end else begin
            r_d.left = r_q.left - rxf_pkg::COUNT_ONE;
          end
        end
      end
      default: begin
        r_d.state = rxf_pkg::PACE_IDLE;
        r_d.req   = 1'b0;
      end
    endcase
    if (sw_reset_i) begin
      r_d.state = rxf_pkg::PACE_IDLE;
      r_d.left  = rxf_pkg::COUNT_ZERO;
      r_d.req   = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_q.state <= rxf_pkg::PACE_IDLE;
      r_q.left  <= 5'h00;
      r_q.req   <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  assign bus_req_o    = r_q.req;
  assign burst_left_o = r_q.left;

endmodule

// ==== testbench/dma_mem_model.sv ====
`timescale 1ns/1ps
module dma_mem_model (
  input  wire logic       mclk_i,      // System clock
  input  wire logic       rst_n_i,     // Async reset, low
  input  wire logic       bus_req_i,   // Bus request
  input  wire logic [1:0] gap_i,       // Grant delay
  output logic            grant_o,     // Bus granted
  output logic            read_done_o  // One word read
);
  logic [1:0] wait_q;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      grant_o <= 1'b0;
      read_done_o <= 1'b0;
      wait_q <= 2'h0;
    end else begin
      read_done_o <= 1'b0;
      if (!bus_req_i) begin
        grant_o <= 1'b0;
        wait_q <= 2'h0;
      end else if (!grant_o) begin
        wait_q <= wait_q + 2'h1;
        if (wait_q >= gap_i) grant_o <= 1'b1;
      end else if (!read_done_o) begin
        read_done_o <= 1'b1;
      end
    end
  end
endmodule

// ==== testbench/rx_filter_top_asserts.sv ====
`timescale 1ns/1ps
module rx_filter_top_asserts (
  input wire logic                       mclk_i,
  input wire logic                       rst_n_i,
  input wire logic                       sw_reset_i,
  input wire logic                       reg_cs_i,
  input wire logic                       reg_rd_i,
  input wire logic [15:0]                reg_rdata_o,
  input wire logic                       frame_end_i,
  input wire rxf_pkg::rx_frame_info_type frame_info_i,
  input wire logic                       frame_accept_o,
  input wire logic                       frame_reject_o,
  input wire logic                       desc_status_valid_o,
  input wire logic [15:0]                desc_status_o,
  input wire rxf_pkg::tx_dma_cfg_type    tx_cfg_i,
  input wire logic [4:0]                 tx_fifo_words_i,
  input wire logic                       dma_grant_i,
  input wire logic                       dma_read_done_i,
  input wire logic                       dma_bus_req_o,
  input wire logic [4:0]                 dma_burst_left_o
);
  logic [4:0] lvl;
  logic [4:0] exp_left;
  always_comb begin
    case (tx_cfg_i.tx_fifo_level_code)
      2'h0: lvl = rxf_pkg::TX_LVL_0;
      2'h1: lvl = rxf_pkg::TX_LVL_1;
      2'h2: lvl = rxf_pkg::TX_LVL_2;
      default: lvl = rxf_pkg::TX_LVL_3;
    endcase
    exp_left = rxf_pkg::TX_FIFO_WORDS - tx_fifo_words_i;
    if (tx_cfg_i.dma_burst_mode_select && lvl < exp_left) exp_left = lvl;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_one_verdict: assert property (
    frame_end_i |=> frame_accept_o ^ frame_reject_o) else $error("no single verdict");
  a_no_verdict: assert property (
    !frame_end_i |=> !frame_accept_o && !frame_reject_o) else $error("stray verdict");
  a_desc_valid: assert property (
    desc_status_valid_o == frame_accept_o) else $error("desc valid mismatch");
  a_rd_idle: assert property (
    !(reg_cs_i && reg_rd_i) |=> reg_rdata_o == rxf_pkg::RDATA_IDLE) else $error("rdata not idle");
  a_mcast_seen: assert property (
    frame_accept_o && $past(frame_info_i.dest_multicast) |-> desc_status_o[8])
    else $error("multicast bit missing");
  a_crc_only: assert property (
    frame_accept_o && $past(frame_info_i.checksum_fault && frame_info_i.framing_fault)
    |-> desc_status_o[2] && !desc_status_o[3]) else $error("framing bit wrong");
  a_req_raise: assert property (
    !dma_bus_req_o && !sw_reset_i && tx_fifo_words_i < lvl |=> dma_bus_req_o)
    else $error("no bus request");
  a_burst_len: assert property (
    $rose(dma_grant_i) && dma_bus_req_o |=> dma_burst_left_o == $past(exp_left))
    else $error("burst length wrong");
  a_burst_end: assert property (
    dma_read_done_i && dma_burst_left_o == 5'h01 && !sw_reset_i |=> !dma_bus_req_o)
    else $error("request held past burst");
endmodule
bind rx_filter_top rx_filter_top_asserts chk (.mclk_i, .rst_n_i, .sw_reset_i, .reg_cs_i,
  .reg_rd_i, .reg_rdata_o, .frame_end_i, .frame_info_i, .frame_accept_o, .frame_reject_o,
  .desc_status_valid_o, .desc_status_o, .tx_cfg_i, .tx_fifo_words_i, .dma_grant_i,
  .dma_read_done_i, .dma_bus_req_o, .dma_burst_left_o);

// ==== testbench/rx_filter_top_tb.sv ====
`timescale 1ns/1ps
module rx_filter_top_tb;
  logic mclk_i, rst_n_i, sw_reset_i, reg_cs_i, reg_wr_i, reg_rd_i, took, rq;
  logic frame_start_i, frame_end_i, carrier_i, frame_accept_o, frame_reject_o;
  logic desc_status_valid_o, dma_grant_i, dma_read_done_i, dma_bus_req_o;
  logic [5:0] reg_sel_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, desc_status_o, ctrl_m;
  logic [4:0] tx_fifo_words_i, dma_burst_left_o, lv;
  logic [1:0] loop_select_o, gap;
  rxf_pkg::rx_frame_info_type frame_info_i, fi;
  rxf_pkg::tx_dma_cfg_type tx_cfg_i;
  int failures, n_compared, cyc, nrd;
  logic [16:0] q_frame[$];
  logic [16:0] q_rd[$];
  logic [16:0] q_dma[$];
  rx_filter_top uut (.mclk_i, .rst_n_i, .sw_reset_i, .reg_sel_i, .reg_cs_i, .reg_wr_i,
    .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .frame_start_i, .frame_end_i, .frame_info_i,
    .carrier_i, .frame_accept_o, .frame_reject_o, .desc_status_valid_o, .desc_status_o,
    .loop_select_o, .tx_cfg_i, .tx_fifo_words_i, .dma_grant_i, .dma_read_done_i,
    .dma_bus_req_o, .dma_burst_left_o);
  dma_mem_model mem (.mclk_i, .rst_n_i, .bus_req_i(dma_bus_req_o), .gap_i(gap),
    .grant_o(dma_grant_i), .read_done_o(dma_read_done_i));
  task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic reg_wr(input logic [15:0] d);
    @(negedge mclk_i);
    {reg_cs_i, reg_wr_i, reg_sel_i, reg_wdata_i} = {2'b11, rxf_pkg::CTRL_SEL, d};
    ctrl_m[15:9] = d[15:9];
    @(negedge mclk_i);
    {reg_cs_i, reg_wr_i} = 2'b00;
  endtask
  task automatic reg_rd(input logic [5:0] sel, input logic [15:0] exp);
    @(negedge mclk_i);
    {reg_cs_i, reg_rd_i, reg_sel_i} = {2'b11, sel};
    q_rd.push_back({1'b0, exp});
    @(negedge mclk_i);
    {reg_cs_i, reg_rd_i} = 2'b00;
  endtask
  task automatic frame(input rxf_pkg::rx_frame_info_type f);
    logic a;
    logic g;
    g = !(f.checksum_fault | f.framing_fault | f.short_frame | f.collision);
    a = (f.dest_match | (ctrl_m[13] & f.dest_broadcast) | (ctrl_m[12] & !f.dest_multicast)
      | (ctrl_m[11] & (f.dest_multicast | f.dest_broadcast)))
      & (ctrl_m[15] | !(f.checksum_fault | f.collision))
      & (ctrl_m[14] | !f.short_frame);
    ctrl_m = ctrl_m & ~rxf_pkg::CTRL_NEXT_CLR;
    if (a) ctrl_m[8:0] = {f.dest_multicast, f.dest_broadcast, f.final_frame_in_area, 1'b0,
      f.collision, f.checksum_fault & !f.framing_fault, f.checksum_fault & f.framing_fault,
      f.looped & (ctrl_m[10:9] != 2'b00) & g, g};
    q_frame.push_back(a ? {1'b1, ctrl_m} : 17'h00000);
    @(negedge mclk_i);
    frame_start_i = 1'b1;
    @(negedge mclk_i);
    {frame_start_i, frame_end_i, frame_info_i} = {2'b01, f};
    @(negedge mclk_i);
    frame_end_i = 1'b0;
  endtask
  // ****************************************
  // Result watcher
  // ****************************************
  always @(posedge mclk_i) took <= reg_cs_i & reg_rd_i;
  always @(negedge mclk_i) begin
    if (took) check("rdata", q_rd.pop_front(), {1'b0, reg_rdata_o});
    if (frame_accept_o | frame_reject_o)
      check("frame", q_frame.pop_front(), frame_accept_o ? {1'b1, desc_status_o} : 17'h0);
    if (dma_read_done_i) nrd++;
    if (rq && !dma_bus_req_o) begin
      check("reads", q_dma.pop_front(), 17'(nrd));
      nrd = 0;
    end
    rq = dma_bus_req_o;
  end
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  initial begin
    {rst_n_i, sw_reset_i, reg_cs_i, reg_wr_i, reg_rd_i} = '0;
    {frame_start_i, frame_end_i, carrier_i, reg_sel_i, reg_wdata_i, frame_info_i} = '0;
    {tx_cfg_i, gap, ctrl_m} = '0;
    tx_fifo_words_i = rxf_pkg::TX_FIFO_WORDS;
    void'($urandom(10));
    repeat (10) @(negedge mclk_i);
    rst_n_i = 1'b1;
    reg_rd(rxf_pkg::CTRL_SEL, 16'h0000);
    reg_rd(6'h03, 16'h0000);
    reg_wr(16'hFFFF);
    reg_rd(rxf_pkg::CTRL_SEL, 16'hFE00);
    @(negedge mclk_i);
    sw_reset_i = 1'b1;
    @(negedge mclk_i);
    sw_reset_i = 1'b0;
    reg_rd(rxf_pkg::CTRL_SEL, 16'hFE00);
    $display("register test done");
    for (int m = 0; m < 32; m++) begin
      reg_wr({m[4:0], 2'($urandom), 9'h000});
      repeat (2) @(negedge mclk_i);
      check("loop", {15'h0, ctrl_m[10:9]}, {15'h0, loop_select_o});
      for (int k = 0; k < 8; k++) begin
        fi = 9'($urandom);
        frame(fi);
      end
      reg_rd(rxf_pkg::CTRL_SEL, ctrl_m);
    end
    carrier_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    reg_rd(rxf_pkg::CTRL_SEL, ctrl_m | 16'h0020);
    carrier_i = 1'b0;
    $display("filter test done");
    for (int i = 0; i < 8; i++) begin
      tx_cfg_i = {i[1:0], i[2]};
      gap = 2'($urandom);
      lv = i[1] ? (i[0] ? rxf_pkg::TX_LVL_3 : rxf_pkg::TX_LVL_2)
                : (i[0] ? rxf_pkg::TX_LVL_1 : rxf_pkg::TX_LVL_0);
      tx_fifo_words_i = lv;
      repeat (4) @(negedge mclk_i);
      check("idle", 17'h0, {16'h0, dma_bus_req_o});
      tx_fifo_words_i = 5'($urandom_range(int'(lv) - 1));
      q_dma.push_back(17'(i[2] && lv < 5'h10 - tx_fifo_words_i ? lv
                                 : 5'h10 - tx_fifo_words_i));
      repeat (2) @(negedge mclk_i);
      check("req", 17'h1, {16'h0, dma_bus_req_o});
      while (dma_bus_req_o) @(negedge mclk_i);
      tx_fifo_words_i = rxf_pkg::TX_FIFO_WORDS;
    end
    repeat (3) @(negedge mclk_i);
    $display("dma test done");
    test_done();
  end
endmodule
